// >>> src/ebac_pkg.sv
// Constants and types shared by the external bus area controller.
package ebac_pkg;

	// ----------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------
	localparam logic [15:0] EBAC_IDX_WIDTH = 16'hFFEC;
	localparam logic [15:0] EBAC_IDX_STCNT = 16'hFFED;
	localparam logic [15:0] EBAC_IDX_WMODE = 16'hFFEE;
	localparam logic [15:0] EBAC_IDX_WGEN = 16'hFFEF;
	localparam logic [15:0] EBAC_IDX_BREL = 16'hFFF3;

	// ----------------------------------------
	// Reset values and fixed bits
	// ----------------------------------------
	localparam logic [7:0] EBAC_WIDTH_RST_8BIT = 8'hFF;
	localparam logic [7:0] EBAC_WIDTH_RST_16BIT = 8'h00;
	localparam logic [7:0] EBAC_STCNT_RST = 8'hFF;
	localparam logic [7:0] EBAC_WMODE_RST = 8'hF3;
	localparam logic [7:0] EBAC_WMODE_FIXED = 8'hF0;
	localparam logic [7:0] EBAC_WGEN_RST = 8'hFF;
	localparam logic [7:0] EBAC_BREL_RST = 8'hFE;
	localparam logic [7:0] EBAC_BREL_FIXED = 8'h1E;
	localparam logic [7:0] EBAC_BREL_HI_MASK = 8'hE0;
	localparam int EBAC_BREL_ENABLE_BIT = 0;

	// ----------------------------------------
	// Wait mode field encodings
	// ----------------------------------------
	localparam logic [1:0] EBAC_WM_PROG = 2'h0;
	localparam logic [1:0] EBAC_WM_NONE = 2'h1;
	localparam logic [1:0] EBAC_WM_PIN1 = 2'h2;
	localparam logic [1:0] EBAC_WM_AUTO = 2'h3;

	// ----------------------------------------
	// Owners, one-hot: cpu, dma_unit, refresh, external master
	// ----------------------------------------
	localparam logic [3:0] EBAC_OWN_CPU = 4'h1;
	localparam logic [3:0] EBAC_OWN_DMA = 4'h2;
	localparam logic [3:0] EBAC_OWN_REF = 4'h4;
	localparam logic [3:0] EBAC_OWN_EXT = 4'h8;

	// ----------------------------------------
	// Bus cycle states
	// ----------------------------------------
	typedef enum logic [4:0] {
		EBAC_IDLE = 5'h01,
		EBAC_T1 = 5'h02,
		EBAC_T2 = 5'h04,
		EBAC_TW = 5'h08,
		EBAC_T3 = 5'h10
	} ebac_state_type;

endpackage : ebac_pkg

// >>> src/ebac_ctrl.sv
// External bus area controller with APB registers, wait-state logic and bus arbiter.
`timescale 1ns/1ps

module ebac_ctrl import ebac_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Operating mode strap, 0 to 3 for modes 1 to 4
	input wire logic [1:0] mode_sel,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Internal masters: request per master, access port of the granted one
	input wire logic [2:0] mst_req,
	output logic [2:0] mst_grant,
	input wire logic acc_valid,
	input wire logic [23:0] acc_addr,
	input wire logic acc_write,
	input wire logic acc_word,
	input wire logic [15:0] acc_wdata,
	output logic acc_done,
	output logic [15:0] acc_rdata,
	// External bus
	output logic [23:0] ext_addr,
	output logic bus_drive_en,
	output logic [3:0] area_select_n,
	output logic addr_valid_strobe_n,
	output logic read_strobe_n,
	output logic upper_byte_write_strobe_n,
	output logic lower_byte_write_strobe_n,
	output logic [15:0] data_out,
	output logic [1:0] data_oe,
	input wire logic [15:0] data_in,
	output logic bus_8bit_mode,
	input wire logic wait_req_n,
	// Bus release to an external master
	input wire logic bus_release_request_n,
	output logic bus_release_ack_n
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		ebac_state_type st;
		logic [3:0] owner;
		logic [7:0] width;
		logic [7:0] stcnt;
		logic [7:0] wmode;
		logic [7:0] wgen;
		logic [7:0] brel;
		logic init;
		logic [1:0] wcnt;
		logic second;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic wr;
		logic word;
		logic three;
		logic narrow;
		logic [2:0] area;
		logic done;
		logic [31:0] prdata;
	} ebac_regs_type;

	ebac_regs_type s_r;
	ebac_regs_type s_nxt;
	logic [2:0] area_nxt;
	logic [3:0] own_nxt;
	logic ext_req;
	logic pin_wait;
	logic auto_wait;
	logic last_state;
	logic upper_lane;
	logic [7:0] lane_byte;
	logic [7:0] wr_byte;
	logic mode16m;

	assign mode16m = mode_sel[1];
	assign ext_req = ~bus_release_request_n & s_r.brel[EBAC_BREL_ENABLE_BIT];
	assign area_nxt = mode16m ? acc_addr[23:21] : {1'b0, acc_addr[18:17]} | {acc_addr[19], 2'h0};
	assign pin_wait = ~s_r.wgen[s_r.area] | (s_r.wmode[3:2] == EBAC_WM_PIN1);
	assign auto_wait = s_r.wgen[s_r.area] & (s_r.wmode[3:2] == EBAC_WM_AUTO);
	assign last_state = (s_r.st == EBAC_T3) | (s_r.st == EBAC_T2 & ~s_r.three);
	assign upper_lane = s_r.narrow | (s_r.word & ~s_r.second) | ~s_r.addr[0];
	assign lane_byte = upper_lane ? data_in[15:8] : data_in[7:0];
	assign wr_byte = (s_r.word & ~s_r.second & s_r.narrow) ? s_r.wdata[15:8] : s_r.wdata[7:0];

	// ----------------------------------------
	// Arbiter: refresh, then dma_unit, then external master, then cpu
	// ----------------------------------------
	always_comb begin
		own_nxt = s_r.owner;
		if (s_r.st == EBAC_IDLE) begin
			if (mst_req[2]) begin
				own_nxt = EBAC_OWN_REF;
			end else if (mst_req[1]) begin
				own_nxt = EBAC_OWN_DMA;
			end else if (ext_req) begin
				own_nxt = EBAC_OWN_EXT;
			end else begin
				own_nxt = EBAC_OWN_CPU;
			end
		end
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.owner = own_nxt;
		if (s_r.init) begin
			s_nxt.init = 1'b0;
			s_nxt.width = mode_sel[0] ? EBAC_WIDTH_RST_16BIT : EBAC_WIDTH_RST_8BIT;
		end
		if (psel & ~penable) begin
			s_nxt.prdata = 32'h0;
			case (paddr[17:2])
				EBAC_IDX_WIDTH: s_nxt.prdata[7:0] = s_r.width;
				EBAC_IDX_STCNT: s_nxt.prdata[7:0] = s_r.stcnt;
				EBAC_IDX_WMODE: s_nxt.prdata[7:0] = s_r.wmode;
				EBAC_IDX_WGEN: s_nxt.prdata[7:0] = s_r.wgen;
				EBAC_IDX_BREL: s_nxt.prdata[7:0] = s_r.brel;
				default: s_nxt.prdata = 32'h0;
			endcase
		end
		if (psel & penable & pwrite & pstrb[0]) begin
			case (paddr[17:2])
				EBAC_IDX_WIDTH: s_nxt.width = pwdata[7:0];
				EBAC_IDX_STCNT: s_nxt.stcnt = pwdata[7:0];
				EBAC_IDX_WMODE: s_nxt.wmode = pwdata[7:0] | EBAC_WMODE_FIXED;
				EBAC_IDX_WGEN: s_nxt.wgen = pwdata[7:0];
				EBAC_IDX_BREL: begin
					s_nxt.brel = (pwdata[7:0] & ~EBAC_BREL_HI_MASK) | EBAC_BREL_FIXED;
					s_nxt.brel = mode16m ? s_nxt.brel | (pwdata[7:0] & EBAC_BREL_HI_MASK)
						: s_nxt.brel | (s_r.brel & EBAC_BREL_HI_MASK);
				end
				default: s_nxt.brel = s_r.brel;
			endcase
		end
		case (s_r.st)
			EBAC_IDLE: begin
				if (acc_valid & (own_nxt == s_r.owner) & ~s_r.owner[3]) begin
					s_nxt.st = EBAC_T1;
					s_nxt.addr = acc_addr;
					s_nxt.wr = acc_write;
					s_nxt.word = acc_word;
					s_nxt.wdata = acc_wdata;
					s_nxt.second = 1'b0;
					s_nxt.area = area_nxt;
					s_nxt.three = s_r.stcnt[area_nxt];
					s_nxt.narrow = s_r.width[area_nxt];
				end
			end
			EBAC_T1: begin
				s_nxt.st = EBAC_T2;
				s_nxt.wcnt = 2'h0;
				if (s_r.wgen[s_r.area] & ((s_r.wmode[3:2] == EBAC_WM_PROG) | (s_r.wmode[3:2] == EBAC_WM_PIN1))) begin
					s_nxt.wcnt = s_r.wmode[1:0];
				end
			end
			EBAC_T2, EBAC_TW: begin
				if (~s_r.three) begin
					s_nxt.st = EBAC_IDLE;
				end else if (s_r.wcnt != 2'h0) begin
					s_nxt.st = EBAC_TW;
					s_nxt.wcnt = s_r.wcnt - 2'h1;
				end else if (pin_wait & ~wait_req_n) begin
					s_nxt.st = EBAC_TW;
				end else if (s_r.st == EBAC_T2 & auto_wait & ~wait_req_n & s_r.wmode[1:0] != 2'h0) begin
					s_nxt.st = EBAC_TW;
					s_nxt.wcnt = s_r.wmode[1:0] - 2'h1;
				end else begin
					s_nxt.st = EBAC_T3;
				end
			end
			EBAC_T3: s_nxt.st = EBAC_IDLE;
			default: s_nxt.st = EBAC_IDLE;
		endcase
		if (last_state) begin
			if (~s_r.wr) begin
				if (s_r.word & ~s_r.narrow) begin
					s_nxt.rdata = data_in;
				end else if (s_r.word & ~s_r.second) begin
					s_nxt.rdata[15:8] = lane_byte;
				end else begin
					s_nxt.rdata[7:0] = lane_byte;
				end
			end
			if (s_r.word & s_r.narrow & ~s_r.second) begin
				s_nxt.st = EBAC_T1;
				s_nxt.second = 1'b1;
				s_nxt.addr = s_r.addr | 24'h000001;
			end else begin
				s_nxt.st = EBAC_IDLE;
				s_nxt.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_r <= '0;
			s_r.st <= EBAC_IDLE;
			s_r.owner <= EBAC_OWN_CPU;
			s_r.width <= EBAC_WIDTH_RST_8BIT;
			s_r.stcnt <= EBAC_STCNT_RST;
			s_r.wmode <= EBAC_WMODE_RST;
			s_r.wgen <= EBAC_WGEN_RST;
			s_r.brel <= EBAC_BREL_RST;
			s_r.init <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	logic in_cycle;
	logic wr_phase;
	assign in_cycle = s_r.st != EBAC_IDLE;
	assign wr_phase = s_r.wr & ((s_r.st == EBAC_T2) | (s_r.st == EBAC_TW));

	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign mst_grant = s_r.owner[2:0];
	assign acc_done = s_r.done;
	assign acc_rdata = s_r.rdata;
	assign ext_addr = s_r.addr;
	assign bus_drive_en = ~s_r.owner[3];
	assign bus_8bit_mode = &s_r.width;
	assign bus_release_ack_n = ~s_r.owner[3];
	assign addr_valid_strobe_n = ~in_cycle;
	assign read_strobe_n = ~(in_cycle & ~s_r.wr);
	assign upper_byte_write_strobe_n = ~(wr_phase & upper_lane);
	assign lower_byte_write_strobe_n = ~(wr_phase & ~s_r.narrow & (s_r.word | s_r.addr[0]));
	assign data_out = (s_r.word & ~s_r.narrow) ? s_r.wdata : {wr_byte, wr_byte};
	assign data_oe = {2{in_cycle & s_r.wr}};

	always_comb begin
		area_select_n = 4'hF;
		if (in_cycle & ~s_r.area[2]) begin
			area_select_n[s_r.area[1:0]] = 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	one_owner_a: assert property ($onehot(s_r.owner)) else $error("Owner is not one-hot.");
	ack_ext_a: assert property (!bus_release_ack_n |-> !bus_release_request_n || $past(!bus_release_request_n))
		else $error("Acknowledge without request.");
	owner_hold_a: assert property (in_cycle |-> $stable(s_r.owner)) else $error("Owner changed mid cycle.");
	two_state_a: assert property (s_r.st == EBAC_T2 && !s_r.three |=> s_r.st != EBAC_TW && s_r.st != EBAC_T3)
		else $error("Two-state cycle stretched.");
	prog_wait_a: assert property (s_r.st == EBAC_T1 && s_r.three && s_r.wgen[s_r.area]
		&& s_r.wmode[3:0] == 4'h3 |=> s_r.st == EBAC_T2 ##1 s_r.st == EBAC_TW [*3] ##1 s_r.st == EBAC_T3)
		else $error("Programmed wait count wrong.");
	no_wait_a: assert property (s_r.st == EBAC_T1 && s_r.three && s_r.wgen[s_r.area]
		&& s_r.wmode[3:2] == EBAC_WM_NONE |=> ##1 s_r.st == EBAC_T3) else $error("Wait in no-wait mode.");
	pin0_wait_a: assert property (s_r.st == EBAC_T2 && s_r.three && !s_r.wgen[s_r.area] && !wait_req_n
		|=> s_r.st == EBAC_TW) else $error("Pin wait 0 ignored.");
	as_valid_a: assert property ($rose(!addr_valid_strobe_n) |-> $changed(ext_addr) || $past(s_r.st) == EBAC_IDLE)
		else $error("Strobe without new address.");
	read_strobe_a: assert property (!read_strobe_n |-> !addr_valid_strobe_n && !s_r.wr)
		else $error("Read strobe outside read.");
	upper_wr_a: assert property (!upper_byte_write_strobe_n |-> data_oe[1] && s_r.wr)
		else $error("Upper strobe without data.");
	lower_wr_a: assert property (!lower_byte_write_strobe_n |-> data_oe[0] && !s_r.narrow)
		else $error("Lower strobe on 8-bit area.");
	cs_area_a: assert property (!area_select_n[0] |-> s_r.area == 3'h0 && in_cycle)
		else $error("Select 0 outside area 0.");
	width_init_a: assert property ($fell(s_r.init) |-> s_r.width == (mode_sel[0] ? 8'h00 : 8'hFF))
		else $error("Width reset value wrong.");

	ext_grant_c: cover property (!bus_release_ack_n);
	word_narrow_c: cover property (s_r.second && acc_done);
	pin_wait_c: cover property (s_r.st == EBAC_TW && pin_wait);
	auto_wait_c: cover property (s_r.st == EBAC_TW && auto_wait);

endmodule : ebac_ctrl

// >>> verif/ebac_far_model.sv
// External memory, wait source and external master model for the bus controller bench.
`timescale 1ns/1ps

module ebac_far_model (
	// Clock
	input wire logic clock,
	// Bus from the controller
	input wire logic [23:0] ext_addr,
	input wire logic addr_valid_strobe_n,
	input wire logic read_strobe_n,
	output logic [15:0] data_in,
	output logic wait_req_n,
	// Bench controls
	input wire logic [3:0] wait_len,
	input wire logic want_bus,
	output logic bus_release_request_n
);
	logic [3:0] cnt_r;

	initial begin
		cnt_r = 4'h0;
		data_in = 16'h0000;
		bus_release_request_n = 1'b1;
	end

	// The wait pin is low for wait_len cycles from the second state of a cycle.
	assign wait_req_n = !(cnt_r != 4'h0 && cnt_r <= wait_len);

	// Read data shows the low address byte on both lanes, and toggles when not read.
	always @(posedge clock) begin
		cnt_r <= addr_valid_strobe_n ? 4'h0 : cnt_r + 4'h1;
		data_in <= !read_strobe_n ? {2{ext_addr[7:0]}} : ~data_in;
		bus_release_request_n <= !want_bus;
	end
endmodule : ebac_far_model

// >>> verif/external_bus_area_controller_tb_top.sv
// Self-checking bench for the external bus area controller.
`timescale 1ns/1ps

module external_bus_area_controller_tb_top import ebac_pkg::*;;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [1:0] mode_sel = 2'h0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_valid = 1'b0, acc_write = 1'b0;
	logic acc_word = 1'b0, want_bus = 1'b0;
	logic [31:0] paddr = 32'h00000000, pwdata = 32'h00000000, prdata, q;
	logic [3:0] pstrb = 4'hF, wait_len = 4'h0, area_select_n, cs;
	logic [2:0] mst_req = 3'h1, mst_grant, f;
	logic [23:0] acc_addr = 24'h000000, ext_addr;
	logic [15:0] acc_wdata = 16'h0000, acc_rdata, data_out, data_in;
	logic [1:0] data_oe;
	logic pready, pslverr, acc_done, bus_drive_en, addr_valid_strobe_n, read_strobe_n;
	logic upper_byte_write_strobe_n, lower_byte_write_strobe_n, bus_8bit_mode, wait_req_n;
	logic bus_release_request_n, bus_release_ack_n;
	int n_mismatch = 0, total_checks = 0, n;

	typedef struct packed {
		logic [7:0] st, wm, we;
		logic [23:0] a;
		logic w;
		logic [3:0] wn, cyc, cs;
		logic [2:0] f;
	} ebac_row_type;

	localparam ebac_row_type ROWS [9] = '{
		'{8'h00, 8'hF3, 8'hFF, 24'h000010, 1'b0, 4'h2, 4'h3, 4'hE, 3'h4},
		'{8'hFF, 8'hF0, 8'hFF, 24'h020011, 1'b0, 4'h0, 4'h4, 4'hD, 3'h4},
		'{8'hFF, 8'hF3, 8'hFF, 24'h040012, 1'b1, 4'h0, 4'h7, 4'hB, 3'h2},
		'{8'hFF, 8'hF5, 8'hFF, 24'h060013, 1'b0, 4'h2, 4'h4, 4'h7, 3'h4},
		'{8'hFF, 8'hF9, 8'hFF, 24'h080014, 1'b0, 4'h0, 4'h5, 4'hF, 3'h4},
		'{8'hFF, 8'hFD, 8'hFF, 24'h0A0015, 1'b0, 4'h1, 4'h5, 4'hF, 3'h4},
		'{8'hFF, 8'hFD, 8'hFF, 24'h0C0016, 1'b0, 4'h0, 4'h4, 4'hF, 3'h4},
		'{8'hFF, 8'hF0, 8'h00, 24'h0E0017, 1'b0, 4'h3, 4'h7, 4'hF, 3'h4},
		'{8'hFF, 8'hF2, 8'hFF, 24'h000018, 1'b0, 4'h0, 4'h6, 4'hE, 3'h4}
	};
	localparam logic [15:0] RIDX [5] = '{EBAC_IDX_WIDTH, EBAC_IDX_STCNT, EBAC_IDX_WMODE, EBAC_IDX_WGEN, EBAC_IDX_BREL};
	localparam logic [7:0] RVAL [5] = '{8'h00, 8'hFF, 8'hF3, 8'hFF, 8'hFE};

	ebac_ctrl u_ebac_ctrl (.*);
	ebac_far_model u_ebac_far_model (.*);

	always #5 clock = ~clock;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	task automatic quit();
		n_mismatch++;
		summarize();
	endtask : quit

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] ra(input logic [15:0] idx);
		return {14'h0000, idx, 2'h0};
	endfunction : ra

	task automatic apb(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [31:0] r);
		int i;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clock);
		penable <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clock);
			if (pready === 1'b1) break;
		end
		if (i == 50) quit();
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [31:0] r;
		apb(1'b1, ra(idx), d, r);
	endtask : wr

	task automatic rchk(input logic [15:0] idx, input logic [7:0] e);
		logic [31:0] r;
		apb(1'b0, ra(idx), 8'h00, r);
		chk(r, {24'h000000, e});
	endtask : rchk

	task automatic acc(input logic [23:0] a, input logic w, output int c, output logic [3:0] s, output logic [2:0] g);
		c = 0;
		s = 4'hF;
		g = 3'h0;
		@(posedge clock);
		acc_addr <= a;
		acc_write <= w;
		acc_wdata <= {2{a[7:0]}};
		acc_valid <= 1'b1;
		do begin
			@(posedge clock);
			#1;
			c++;
			s &= area_select_n;
			g |= {!read_strobe_n, !upper_byte_write_strobe_n, !lower_byte_write_strobe_n};
		end while (acc_done !== 1'b1 && c < 60);
		if (c == 60) quit();
		acc_valid <= 1'b0;
	endtask : acc

	task automatic await_own(input logic [3:0] v);
		int i;
		for (i = 0; i < 100; i++) begin
			@(posedge clock);
			if ({bus_release_ack_n, mst_grant} === v) break;
		end
		chk({bus_release_ack_n, mst_grant}, v);
		if (i == 100) quit();
	endtask : await_own

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		repeat (2) @(posedge clock);
		rchk(EBAC_IDX_WIDTH, 8'hFF);
		foreach (ROWS[k]) begin
			wait_len <= ROWS[k].wn;
			wr(EBAC_IDX_STCNT, ROWS[k].st);
			wr(EBAC_IDX_WMODE, ROWS[k].wm);
			wr(EBAC_IDX_WGEN, ROWS[k].we);
			acc(ROWS[k].a, ROWS[k].w, n, cs, f);
			chk(n, ROWS[k].cyc);
			chk(cs, ROWS[k].cs);
			chk(f, ROWS[k].f);
			if (!ROWS[k].w) chk(acc_rdata[7:0], ROWS[k].a[7:0]);
		end
		wr(EBAC_IDX_WMODE, 8'h03);
		rchk(EBAC_IDX_WMODE, 8'hF3);
		wr(16'hFFF0, 8'hFF);
		rchk(16'hFFF0, 8'h00);
		chk(pslverr, 1'b0);
		apb(1'b0, 32'h8003FFB0, 8'h00, q);
		chk(q, 32'h000000FF);
		chk(bus_8bit_mode, 1'b1);
		want_bus <= 1'b1;
		repeat (20) @(posedge clock);
		chk(bus_release_ack_n, 1'b1);
		wr(EBAC_IDX_BREL, 8'hFF);
		await_own(4'h0);
		chk(bus_drive_en, 1'b0);
		want_bus <= 1'b0;
		await_own(4'h9);
		mst_req <= 3'h3;
		await_own(4'hA);
		mst_req <= 3'h5;
		await_own(4'hC);
		mst_req <= 3'h1;
		await_own(4'h9);
		rst <= 1'b1;
		mode_sel <= 2'h3;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		wait_len <= 4'h0;
		repeat (2) @(posedge clock);
		foreach (RIDX[k]) rchk(RIDX[k], RVAL[k]);
		chk(bus_8bit_mode, 1'b0);
		acc(24'h200001, 1'b1, n, cs, f);
		chk(cs, 4'hD);
		chk(f, 3'h1);
		acc(24'h400002, 1'b1, n, cs, f);
		chk({cs, 1'b0, f}, 8'hB2);
		chk(data_out, 16'h0202);
		chk(data_oe, 2'h0);
		wr(EBAC_IDX_WIDTH, 8'hFF);
		@(posedge clock);
		acc_word <= 1'b1;
		acc(24'h600004, 1'b0, n, cs, f);
		chk(acc_rdata, 16'h0405);
		chk({cs, 1'b0, f}, 8'h74);
		chk(ext_addr, 24'h600005);
		@(posedge clock);
		acc_word <= 1'b0;
		summarize();
	end
endmodule : external_bus_area_controller_tb_top
